// [logic/afm_device.sv]
/*
 Device end: command decoder, audio input fault supervision, playback sound
 check and flash pass-through. Assumes the host keeps its side of the link
 and that frame clock, audio data and feedback arrive asynchronously.
*/
`timescale 1ns/1ps
`include "afm_cfg.svh"
module afm_device
	import afm_pkg::*;
#(
	parameter int IDLE_LIMIT_CYC = `AFM_IDLE_LIMIT_MS * (`AFM_CLK_HZ / 1000)
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	afm_link_if.dev   link,
	input  wire logic frameClkPin,
	input  wire logic audioDinPin,
	input  wire logic flashBypassPin,
	input  wire logic flashDin,
	input  wire logic pcmBit,
	input  wire logic feedbackInA,
	input  wire logic feedbackInB,
	output logic      flashCsNOut,
	output logic      flashCsNOe,
	output logic      flashClkOut,
	output logic      flashClkOe,
	output logic      flashDoutOut,
	output logic      flashDoutOe,
	output logic      speakerOutPos,
	output logic      speakerOutNeg
);
	// Frame period in clk_sys cycles for a rate code, shortened by the overspeed margin.
	function automatic logic [11:0] framePeriod(input logic [3:0] fs);
		int hz;
		hz = `AFM_HZ_8K;
		unique case (fs)
			`AFM_FS_16K: hz = `AFM_HZ_16K;
			`AFM_FS_32K: hz = `AFM_HZ_32K;
			`AFM_FS_11K: hz = `AFM_HZ_11K;
			`AFM_FS_22K: hz = `AFM_HZ_22K;
			`AFM_FS_44K: hz = `AFM_HZ_44K;
			`AFM_FS_12K: hz = `AFM_HZ_12K;
			`AFM_FS_24K: hz = `AFM_HZ_24K;
			`AFM_FS_48K: hz = `AFM_HZ_48K;
			default: hz = `AFM_HZ_8K;
		endcase
		return 12'(((`AFM_CLK_HZ / hz) * (100 - `AFM_FAST_PCT)) / 100);
	endfunction

	// True for the rate groups that lose channel 3 to the audio input.
	function automatic logic highRate(input logic [3:0] fs);
		return (fs >= `AFM_FS_11K) && (fs <= `AFM_FS_48K);
	endfunction

	logic devRst;
	assign devRst = rst | ~link.resetNPin;

	// Synchronised pins.
	logic [4:0] pinsS;
	afm_pin_sync #(.W(5)) uSync (
		.clk_sys (clk_sys),
		.rst     (devRst),
		.pinIn   ({feedbackInB, feedbackInA, flashBypassPin, audioDinPin, frameClkPin}),
		.pinOut  (pinsS)
	);

	afm_pwr_t    pwr_q;        // Power state.
	logic [3:0]  fs_q;         // Sample rate code.
	logic        audio_out_enable_q;      // Audio output enable.
	logic        audio_in_enable_q;       // Audio input enable.
	logic [1:0]  lCh_q;        // Channel fed by the left side.
	logic [1:0]  rCh_q;        // Channel fed by the right side.
	logic        lEn_q;        // Left side enable.
	logic        rEn_q;        // Right side enable.
	logic [4:0]  safe_q;       // Detection enables.
	logic        halted_q;     // Stopped by a fast frame clock.
	logic        silence_play_cmd_q;       // Silence command seen since the halt.
	logic [3:0]  playing_q;    // Channels playing.
	logic [3:0]  err_q;        // Sticky error bits.
	logic [11:0] period_q;     // Cycles since last frame edge.
	logic        seen_q;       // A frame edge has been seen.
	logic [31:0] idle_q;       // Cycles since last data edge.
	logic [1:0]  prev_q;       // Last frame and data levels.
	logic [7:0]  rsp_q;        // Error byte out.
	logic        rspV_q;       // Error byte valid.
	logic [1:0]  exp_q [5];    // Expected speaker levels, delayed.
	logic [2:0]  fl_q;         // Flash cs, clk, dout.
	logic        so_q;         // Flash data back to host.
	logic        take;
	logic [7:0]  op;
	logic [15:0] arg;
	logic        frameEdge;
	logic        fast;
	logic        lineQuiet;
	logic        mixBad;
	logic        sndBad;
	logic        sideOn;
	logic [1:0]  seenFb;

	assign link.cmdReady = ~rspV_q;
	assign take = link.cmdValid & ~rspV_q;
	assign op = link.cmdCode;
	assign arg = link.cmdArg;
	assign link.rspValid = rspV_q;
	assign link.rspData = rsp_q;
	assign link.hostSo = so_q;
	assign frameEdge = pinsS[0] & ~prev_q[0];
	assign sideOn = lEn_q | rEn_q;

	assign fast = frameEdge & seen_q & (audio_in_enable_q | audio_out_enable_q)
		& (period_q != 12'hFFF) & ((period_q + 12'h001) < framePeriod(fs_q));

	assign lineQuiet = safe_q[`AFM_A_LINEEN] & audio_in_enable_q & (idle_q >= 32'(IDLE_LIMIT_CYC));

	always_comb begin
		mixBad = 1'b0;
		if (take && safe_q[`AFM_A_MIX_CHECK_EN] && highRate(fs_q) && pwr_q == PWR_UP) begin
			if ((op == `AFM_OP_PLAY || op == `AFM_OP_PLAY_EXTENDED_CMD || op == `AFM_OP_START
				|| op == `AFM_OP_SILENCE_PLAY_CMD) && sideOn && arg[`AFM_A_CH] == `AFM_MIX_CH) begin
				mixBad = 1'b1;
			end else if (op == `AFM_OP_CHAN && (arg[`AFM_A_LEN] || arg[`AFM_A_REN])
				&& (arg[`AFM_A_LCH] == `AFM_MIX_CH || arg[`AFM_A_RCH] == `AFM_MIX_CH)) begin
				mixBad = 1'b1;
			end
		end
	end

	assign seenFb = safe_q[`AFM_A_FBEXT] ? pinsS[4:3] : {speakerOutNeg, speakerOutPos};
	assign sndBad = safe_q[`AFM_A_SNDEN] & (|playing_q)
		& (seenFb != (safe_q[`AFM_A_FBEXT] ? exp_q[4] : exp_q[0]));

	// Frame and data edge timers.
	always_ff @(posedge clk_sys) begin
		if (devRst) begin
			period_q <= 12'h000;
			seen_q <= 1'b0;
			idle_q <= 32'h0000_0000;
			prev_q <= 2'h0;
		end else begin
			prev_q <= pinsS[1:0];
			if (frameEdge) begin
				period_q <= 12'h000;
				seen_q <= 1'b1;
			end else if (period_q != 12'hFFF) begin
				period_q <= period_q + 12'h001;
			end
			if (pinsS[1] != prev_q[1] || !audio_in_enable_q) begin
				idle_q <= 32'h0000_0000;
			end else if (idle_q < 32'(IDLE_LIMIT_CYC)) begin
				idle_q <= idle_q + 32'h0000_0001;
			end
		end
	end

	// Command decoding and playback state.
	// starts powered down
	always_ff @(posedge clk_sys) begin
		if (devRst) begin
			pwr_q <= PWR_DOWN;
			fs_q <= `AFM_FS_8K;
			{audio_out_enable_q, audio_in_enable_q} <= 2'h0;
			{lCh_q, rCh_q, lEn_q, rEn_q} <= 6'h00;
			safe_q <= 5'h00;
			halted_q <= 1'b0;
			silence_play_cmd_q <= 1'b0;
			playing_q <= 4'h0;
		end else if (fast) begin
			{lCh_q, rCh_q, lEn_q, rEn_q} <= 6'h00;
			playing_q <= 4'h0;
			halted_q <= 1'b1;
			silence_play_cmd_q <= 1'b0;
		end else if (take && !mixBad) begin
			unique case (pwr_q)
				PWR_DOWN: begin
					if (op == `AFM_OP_PUP) begin
						pwr_q <= PWR_UP;
					end
				end
				PWR_DIRECT: begin
					if (op == `AFM_OP_POWER_DOWN_CMD) begin
						pwr_q <= PWR_DOWN;
					end
				end
				PWR_UP: begin
					unique case (op)
						`AFM_OP_POWER_DOWN_CMD: begin
							pwr_q <= PWR_DOWN;
							playing_q <= 4'h0;
						end
						`AFM_OP_FDIR: begin
							if (!pinsS[2]) begin
								pwr_q <= PWR_DIRECT;
							end
						end
						`AFM_OP_PLAY, `AFM_OP_PLAY_EXTENDED_CMD, `AFM_OP_START: begin
							if (!halted_q) begin
								playing_q[arg[`AFM_A_CH]] <= 1'b1;
							end
						end
						`AFM_OP_SILENCE_PLAY_CMD: begin
							playing_q[arg[`AFM_A_CH]] <= 1'b1;
							silence_play_cmd_q <= 1'b1;
						end
						`AFM_OP_STOP: playing_q[arg[`AFM_A_CH]] <= 1'b0;
						`AFM_OP_FMT: begin
							fs_q <= arg[`AFM_A_FS];
							audio_out_enable_q <= arg[`AFM_A_AUDIO_OUT_ENABLE];
							audio_in_enable_q <= arg[`AFM_A_AUDIO_IN_ENABLE];
						end
						`AFM_OP_CHAN: begin
							if (!halted_q || silence_play_cmd_q) begin
								{rEn_q, lEn_q} <= {arg[`AFM_A_REN], arg[`AFM_A_LEN]};
								{rCh_q, lCh_q} <= {arg[`AFM_A_RCH], arg[`AFM_A_LCH]};
								halted_q <= 1'b0;
								silence_play_cmd_q <= 1'b0;
							end
						end
						`AFM_OP_SAFE: safe_q <= arg[4:0];
						default: ;
					endcase
				end
				default: pwr_q <= PWR_DOWN;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (devRst) begin
			err_q <= 4'h0;
		end else begin
			if (take && op == `AFM_OP_ERROR_CLEAR_CMD) begin
				err_q <= 4'h0;
			end
			if (fast && safe_q[`AFM_A_FRAMEEN]) begin
				err_q[`AFM_E_FRAME] <= 1'b1;
			end
			if (lineQuiet) begin
				err_q[`AFM_E_LINE] <= 1'b1;
			end
			if (mixBad) begin
				err_q[`AFM_E_MIX] <= 1'b1;
			end
			if (sndBad) begin
				err_q[`AFM_E_SND] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (devRst) begin
			rspV_q <= 1'b0;
			rsp_q <= 8'h00;
		end else begin
			rspV_q <= take && op == `AFM_OP_ERROR_READ_CMD;
			if (take && op == `AFM_OP_ERROR_READ_CMD) begin
				rsp_q <= {4'h0, err_q};
			end
		end
	end

	// Speaker drive and expected levels; the delay line matches the pin synchroniser.
	always_ff @(posedge clk_sys) begin
		if (devRst) begin
			speakerOutPos <= 1'b0;
			speakerOutNeg <= 1'b0;
			for (int i = 0; i < 5; i++) begin
				exp_q[i] <= 2'h0;
			end
		end else begin
			speakerOutPos <= (|playing_q) & pcmBit;
			speakerOutNeg <= (|playing_q) & ~pcmBit;
			exp_q[0] <= {(|playing_q) & ~pcmBit, (|playing_q) & pcmBit};
			for (int i = 1; i < 5; i++) begin
				exp_q[i] <= exp_q[i-1];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (devRst) begin
			fl_q <= 3'b100;
			so_q <= 1'b0;
		end else if (pwr_q == PWR_DIRECT) begin
			fl_q <= {link.hostCsN, link.hostSck, link.hostSi};
			so_q <= flashDin;
		end else begin
			fl_q <= 3'b100;
			so_q <= 1'b0;
		end
	end

	assign {flashCsNOut, flashClkOut, flashDoutOut} = fl_q;
	assign flashCsNOe = ~pinsS[2];
	assign flashClkOe = ~pinsS[2];
	assign flashDoutOe = ~pinsS[2];
endmodule

// [logic/afm_cfg.svh]
/*
 Fixed numbers of the audio fault monitor: command codes, argument fields,
 sample rate codes and timing figures. Assumes inclusion by bare name.
*/
`ifndef AFM_CFG_SVH
`define AFM_CFG_SVH
// System clock rate in Hz.
`define AFM_CLK_HZ 25000000
// Longest quiet time on the audio data input, in milliseconds.
`define AFM_IDLE_LIMIT_MS 1800
// Frame clock overspeed margin, in percent.
`define AFM_FAST_PCT 5
// One less than the cycles the host holds the reset pin low after its own reset.
`define AFM_RST_PULSE 8'h08
// Command codes.
`define AFM_OP_PUP 8'h01
`define AFM_OP_POWER_DOWN_CMD 8'h02
`define AFM_OP_PLAY 8'h03
`define AFM_OP_PLAY_EXTENDED_CMD 8'h04
`define AFM_OP_START 8'h05
`define AFM_OP_SILENCE_PLAY_CMD 8'h06
`define AFM_OP_STOP 8'h07
`define AFM_OP_FMT 8'h08
`define AFM_OP_CHAN 8'h09
`define AFM_OP_SAFE 8'h0A
`define AFM_OP_ERROR_READ_CMD 8'h0B
`define AFM_OP_ERROR_CLEAR_CMD 8'h0C
`define AFM_OP_FDIR 8'h0D
// Argument fields: channel, format and channel-setup commands.
`define AFM_A_CH 1:0
`define AFM_A_FS 3:0
`define AFM_A_AUDIO_OUT_ENABLE 4
`define AFM_A_AUDIO_IN_ENABLE 5
`define AFM_A_LCH 1:0
`define AFM_A_RCH 3:2
`define AFM_A_LEN 4
`define AFM_A_REN 5
// Detection enables carried by the safety command.
`define AFM_A_FRAMEEN 0
`define AFM_A_LINEEN 1
`define AFM_A_MIX_CHECK_EN 2
`define AFM_A_SNDEN 3
`define AFM_A_FBEXT 4
// Channel that high sample rates take away from playback.
`define AFM_MIX_CH 2'h3
// Error byte bit positions.
`define AFM_E_FRAME 0
`define AFM_E_LINE 1
`define AFM_E_MIX 2
`define AFM_E_SND 3
// Sample rate codes and their rates in Hz.
`define AFM_FS_8K 4'h0
`define AFM_FS_16K 4'h1
`define AFM_FS_32K 4'h2
`define AFM_FS_11K 4'h3
`define AFM_FS_22K 4'h4
`define AFM_FS_44K 4'h5
`define AFM_FS_12K 4'h6
`define AFM_FS_24K 4'h7
`define AFM_FS_48K 4'h8
`define AFM_HZ_8K 8000
`define AFM_HZ_16K 16000
`define AFM_HZ_32K 32000
`define AFM_HZ_11K 11025
`define AFM_HZ_22K 22050
`define AFM_HZ_44K 44100
`define AFM_HZ_12K 12000
`define AFM_HZ_24K 24000
`define AFM_HZ_48K 48000
// Host register byte offsets.
`define AFM_R_CMD 8'h00
`define AFM_R_STAT 8'h04
`define AFM_R_RESP 8'h08
`define AFM_R_IRQ 8'h0C
`define AFM_R_MASK 8'h10
`define AFM_R_FLASH 8'h14
`endif

// [logic/afm_pkg.sv]
/*
 Types shared by both ends of the audio fault monitor.
 Assumes nothing of its surroundings.
*/
package afm_pkg;
	// Power state of the device end.
	typedef enum logic [1:0] {PWR_DOWN, PWR_UP, PWR_DIRECT} afm_pwr_t;
	// Host sequencer state.
	typedef enum logic [1:0] {HS_RESET, HS_IDLE, HS_SEND} afm_host_t;
endpackage

// [logic/afm_link_if.sv]
/*
 Link between host controller and device: command channel, reset pin and
 the host serial lines used for flash pass-through. Both ends share clk_sys.
*/
`timescale 1ns/1ps
interface afm_link_if;
	logic        cmdValid;  // Command offered by the host.
	logic        cmdReady;  // Device can take a command.
	logic [7:0]  cmdCode;   // Command code.
	logic [15:0] cmdArg;    // Command argument.
	logic        rspValid;  // One-cycle pulse with the error byte.
	logic [7:0]  rspData;   // Error byte.
	logic        resetNPin; // Active-low device reset.
	logic        hostCsN;   // Host chip select, active low.
	logic        hostSck;   // Host serial clock.
	logic        hostSi;    // Host serial data to the device.
	logic        hostSo;    // Device serial data to the host.
	modport dev (input cmdValid, cmdCode, cmdArg, resetNPin, hostCsN, hostSck, hostSi,
		output cmdReady, rspValid, rspData, hostSo);
	modport host (output cmdValid, cmdCode, cmdArg, resetNPin, hostCsN, hostSck, hostSi,
		input cmdReady, rspValid, rspData, hostSo);
endinterface

// [logic/afm_pin_sync.sv]
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes the input is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module afm_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);
	// The first stage is read only by the second, which keeps metastability contained.
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// Shift chain.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts only once the second and third stages agree.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pinOut <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					pinOut[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

// [logic/afm_host.sv]
/*
 Host end: Wishbone classic slave registers that issue device commands,
 collect error bytes, raise an interrupt and drive the flash serial lines.
 Assumes a single Wishbone master on clk_sys.
*/
`timescale 1ns/1ps
`include "afm_cfg.svh"
module afm_host
	import afm_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	afm_link_if.host         link,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq
);
	afm_host_t   st_q;     // Sequencer state.
	logic [7:0]  rcnt_q;   // Reset pulse counter.
	logic [23:0] cmd_q;    // Pending command code and argument.
	logic [7:0]  resp_q;   // Last error byte.
	logic [1:0]  ists_q;   // Sticky events: answer, command sent.
	logic [1:0]  imsk_q;   // Interrupt mask.
	logic [2:0]  fl_q;     // cs_n, sck, si.
	logic        wr;
	logic        sent;

	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
	assign sent = (st_q == HS_SEND) & link.cmdReady;
	assign link.cmdValid = (st_q == HS_SEND);
	assign link.cmdCode = cmd_q[7:0];
	assign link.cmdArg = cmd_q[23:8];
	assign {link.hostCsN, link.hostSck, link.hostSi} = fl_q;
	assign irq = |(ists_q & imsk_q);

	assign link.resetNPin = (st_q != HS_RESET);

	// Sequencer; writes to the command register while busy are dropped.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q <= HS_RESET;
			rcnt_q <= 8'h00;
			cmd_q <= 24'h000000;
		end else begin
			unique case (st_q)
				HS_RESET: begin
					rcnt_q <= rcnt_q + 8'h01;
					if (rcnt_q == `AFM_RST_PULSE) begin
						st_q <= HS_IDLE;
					end
				end
				HS_IDLE: begin
					if (wr && wb_adr_i == `AFM_R_CMD && (&wb_sel_i[2:0])) begin
						cmd_q <= wb_dat_i[23:0];
						st_q <= HS_SEND;
					end
				end
				HS_SEND: begin
					if (sent) begin
						st_q <= HS_IDLE;
					end
				end
				default: st_q <= HS_RESET;
			endcase
		end
	end

	// Answer capture, events and control registers; a new event beats a clear.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			resp_q <= 8'h00;
			ists_q <= 2'h0;
			imsk_q <= 2'h0;
			fl_q <= 3'b100;
		end else begin
			if (wr && wb_adr_i == `AFM_R_IRQ && wb_sel_i[0]) begin
				ists_q <= ists_q & ~wb_dat_i[1:0];
			end
			if (wr && wb_adr_i == `AFM_R_MASK && wb_sel_i[0]) begin
				imsk_q <= wb_dat_i[1:0];
			end
			if (wr && wb_adr_i == `AFM_R_FLASH && wb_sel_i[0]) begin
				fl_q <= wb_dat_i[2:0];
			end
			if (link.rspValid) begin
				resp_q <= link.rspData;
				ists_q[0] <= 1'b1;
			end
			if (sent) begin
				ists_q[1] <= 1'b1;
			end
		end
	end

	// Bus answer one cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			unique case (wb_adr_i)
				`AFM_R_CMD: wb_dat_o <= {8'h00, cmd_q};
				`AFM_R_STAT: wb_dat_o <= {30'h0, st_q == HS_RESET, st_q != HS_IDLE};
				`AFM_R_RESP: wb_dat_o <= {24'h000000, resp_q};
				`AFM_R_IRQ: wb_dat_o <= {30'h0, ists_q};
				`AFM_R_MASK: wb_dat_o <= {30'h0, imsk_q};
				`AFM_R_FLASH: wb_dat_o <= {28'h0, link.hostSo, fl_q};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// [bench/afm_link_chk.sv]
/*
 Checker of the link between host and device ends.
 Assumes it is fed the link signals and the shared clock and reset.
*/
`timescale 1ns/1ps
`include "afm_cfg.svh"
module afm_link_chk (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        cmdValid,
	input wire logic        cmdReady,
	input wire logic [7:0]  cmdCode,
	input wire logic [15:0] cmdArg,
	input wire logic        rspValid,
	input wire logic [7:0]  rspData,
	input wire logic        resetNPin
);
	// All checks share one clock and sleep during reset.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// An error read taken by the device.
	wire rdTaken = cmdValid && cmdReady && (cmdCode == `AFM_OP_ERROR_READ_CMD);
	a_rsp_cause: assert property (rspValid |-> $past(rdTaken))
		else $error("error byte without a read");
	a_error_read_cmd_answer: assert property (rdTaken |=> rspValid)
		else $error("error read not answered next cycle");
	a_rsp_pulse: assert property (rspValid |=> !rspValid)
		else $error("answer pulse too long");
	a_ready_rsp: assert property (cmdReady == !rspValid)
		else $error("ready not the inverse of answer");
	a_rsp_stable: assert property (!rdTaken && resetNPin |=> $stable(rspData))
		else $error("error byte moved without answer");
	a_cmd_hold: assert property (cmdValid && !cmdReady |=>
		cmdValid && $stable(cmdCode) && $stable(cmdArg))
		else $error("command dropped before taken");
	a_rst_pulse: assert property ($fell(rst) |-> !resetNPin [*8])
		else $error("device reset pulse too short");
	a_no_cmd_rst: assert property (!resetNPin |-> !cmdValid)
		else $error("command offered during device reset");
	// Main scenarios seen on the link.
	c_read: cover property (rdTaken);
	c_fault: cover property (rspValid && rspData != 8'h00);
	c_release: cover property ($rose(resetNPin));
endmodule

// [bench/tb.sv]
/*
 Self-checking bench: host and device ends joined by the link, host
 driven over Wishbone. Assumes the design files are compiled first.
*/
`timescale 1ns/1ps
`include "afm_cfg.svh"
module tb;
	logic        clk_sys, rst, wbCyc, wbStb, wbWe, wbAck, irq, dinRun;
	logic [7:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbDatI, wbDatO, rd;
	logic        frameClk, audioDin, bypass, flashDin, pcmBit;
	logic        csN, csOe, sck, sckOe, dout, doutOe, spkP, spkN;
	logic [7:0]  expQ[$];   // Error bytes still awaited.
	logic [7:0]  ops[4] = '{`AFM_OP_PLAY, `AFM_OP_PLAY_EXTENDED_CMD, `AFM_OP_START, `AFM_OP_SILENCE_PLAY_CMD};
	logic [15:0] chA[3] = '{16'h0013, 16'h002C, 16'h000F};
	logic [7:0]  chE[3] = '{8'h04, 8'h04, 8'h00};
	int          errorCnt = 0;
	int          nChecks = 0;
	afm_link_if  link();
	// Feedback pins loop back the speaker outputs, as a board would.
	afm_device #(.IDLE_LIMIT_CYC(200)) u_afm_device (.clk_sys(clk_sys), .rst(rst),
		.link(link), .frameClkPin(frameClk), .audioDinPin(audioDin),
		.flashBypassPin(bypass), .flashDin(flashDin), .pcmBit(pcmBit),
		.feedbackInA(spkP), .feedbackInB(spkN), .flashCsNOut(csN), .flashCsNOe(csOe),
		.flashClkOut(sck), .flashClkOe(sckOe), .flashDoutOut(dout),
		.flashDoutOe(doutOe), .speakerOutPos(spkP), .speakerOutNeg(spkN));
	afm_host u_afm_host (.clk_sys(clk_sys), .rst(rst), .link(link), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
		.wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .irq(irq));
	afm_link_chk u_afm_link_chk (.clk_sys(clk_sys), .rst(rst),
		.cmdValid(link.cmdValid), .cmdReady(link.cmdReady), .cmdCode(link.cmdCode),
		.cmdArg(link.cmdArg), .rspValid(link.rspValid), .rspData(link.rspData),
		.resetNPin(link.resetNPin));
	// Clock of 40 ns.
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic printVerdict();
		$display("checks=%0d errors=%0d", nChecks, errorCnt);
		if (errorCnt == 0 && nChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// One classic cycle: hold until ack is sampled, then release.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatI <= d;
		@(posedge clk_sys);
		while (wbAck !== 1'b1) @(posedge clk_sys);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Waits while busy or in device reset, so no command goes early.
	task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
		rd = 32'h3;
		while (rd[1:0] != 2'h0) wb(1'b0, `AFM_R_STAT, 32'h0);
		wb(1'b1, `AFM_R_CMD, {8'h00, arg, op});
	endtask
	task automatic error_read_cmd(input logic [7:0] e);
		expQ.push_back(e);
		cmd(`AFM_OP_ERROR_READ_CMD, 16'h0000);
	endtask
	// Frame clock toggling every 50 cycles, far above any rate.
	task automatic fastFrame();
		repeat (6) begin
			tick(50);
			frameClk <= ~frameClk;
		end
		tick(10);
	endtask
	// Answers are compared in order against the notes of the driver.
	always @(posedge clk_sys) begin
		if (link.rspValid === 1'b1) begin
			if (expQ.size() > 0)
				check(link.rspData, expQ.pop_front());
			else
				check(link.rspData, 32'hFFFF);
		end
	end
	// Random playback bits, and random data while enabled.
	always @(posedge clk_sys) begin
		pcmBit <= 1'($urandom);
		if (dinRun)
			audioDin <= 1'($urandom);
	end
	// Hang guard, well above the expected run.
	initial begin
		tick(40000);
		errorCnt++;
		printVerdict();
	end
	initial begin
		{wbCyc, wbStb, wbWe, wbAdr, wbDatI, dinRun} = '0;
		{frameClk, audioDin, bypass, flashDin, pcmBit} = '0;
		wbSel = 4'hF;
		rst = 1'b1;
		void'($urandom(95750));
		tick(8);
		rst <= 1'b0;
		cmd(`AFM_OP_FDIR, 16'h0000);
		wb(1'b1, `AFM_R_FLASH, 32'h0);
		tick(6);
		check({csN, spkP, spkN}, 3'b100);
		cmd(`AFM_OP_PUP, 16'h0000);
		cmd(`AFM_OP_CHAN, 16'h0010);
		cmd(`AFM_OP_SAFE, 16'h0004);
		// channel 3 per command and rate
		foreach (ops[i]) for (int r = 0; r < 9; r++) begin
			cmd(`AFM_OP_FMT, 16'h0020 | 16'(r));
			cmd(ops[i], 16'h0003);
			error_read_cmd((r > 2) ? 8'h04 : 8'h00);
			cmd(`AFM_OP_ERROR_CLEAR_CMD, 16'h0000);
		end
		// channel setup on channel 3, sticky after legal setup
		foreach (chA[i]) begin
			cmd(`AFM_OP_CHAN, chA[i]);
			cmd(`AFM_OP_CHAN, 16'h0010);
			error_read_cmd(chE[i]);
			cmd(`AFM_OP_ERROR_CLEAR_CMD, 16'h0000);
		end
		// quiet input just under and over the limit
		// line error stays set after data resumes, until cleared
		cmd(`AFM_OP_SAFE, 16'h0002);
		dinRun <= 1'b1;
		tick(20);
		cmd(`AFM_OP_ERROR_CLEAR_CMD, 16'h0000);
		dinRun <= 1'b0;
		tick(150);
		error_read_cmd(8'h00);
		tick(100);
		error_read_cmd(8'h02);
		dinRun <= 1'b1;
		tick(20);
		error_read_cmd(8'h02);
		cmd(`AFM_OP_ERROR_CLEAR_CMD, 16'h0000);
		error_read_cmd(8'h00);
		// fast frame stops playback and flags
		cmd(`AFM_OP_SAFE, 16'h0001);
		cmd(`AFM_OP_PLAY, 16'h0000);
		tick(4);
		check(spkP ^ spkN, 1'b1);
		fastFrame();
		error_read_cmd(8'h01);
		check({spkP, spkN}, 2'b00);
		cmd(`AFM_OP_PLAY, 16'h0001);
		tick(4);
		check({spkP, spkN}, 2'b00);
		cmd(`AFM_OP_SILENCE_PLAY_CMD, 16'h0000);
		cmd(`AFM_OP_CHAN, 16'h0010);
		cmd(`AFM_OP_PLAY, 16'h0001);
		tick(4);
		check(spkP ^ spkN, 1'b1);
		cmd(`AFM_OP_ERROR_CLEAR_CMD, 16'h0000);
		cmd(`AFM_OP_SAFE, 16'h0000);
		fastFrame();
		error_read_cmd(8'h00);
		check({spkP, spkN}, 2'b00);
		// Interrupt raised, masked and cleared; unmapped read is zero.
		wb(1'b1, `AFM_R_MASK, 32'h1);
		wb(1'b1, `AFM_R_IRQ, 32'h3);
		check(irq, 1'b0);
		error_read_cmd(8'h00);
		tick(5);
		check(irq, 1'b1);
		wb(1'b1, `AFM_R_MASK, 32'h0);
		check(irq, 1'b0);
		wb(1'b1, `AFM_R_IRQ, 32'h3);
		wb(1'b0, `AFM_R_IRQ, 32'h0);
		check(rd, 32'h0);
		wb(1'b0, 8'hFC, 32'h0);
		check(rd, 32'h0);
		// host lines pass to the flash
		cmd(`AFM_OP_FDIR, 16'h0000);
		wb(1'b1, `AFM_R_FLASH, 32'h2);
		tick(4);
		check({csN, sck, dout}, 3'b010);
		wb(1'b1, `AFM_R_FLASH, 32'h5);
		flashDin <= 1'b1;
		tick(4);
		check({csN, sck, dout}, 3'b101);
		wb(1'b0, `AFM_R_FLASH, 32'h0);
		check(rd[3], 1'b1);
		// bypass pin floats the flash outputs
		bypass <= 1'b1;
		tick(8);
		check({csOe, sckOe, doutOe}, 3'b000);
		bypass <= 1'b0;
		tick(8);
		check({csOe, sckOe, doutOe}, 3'b111);
		cmd(`AFM_OP_POWER_DOWN_CMD, 16'h0000);
		// reset mid-run after a channel 3 play; both sides are off, so no fault is raised
		cmd(`AFM_OP_PUP, 16'h0000);
		cmd(`AFM_OP_SAFE, 16'h0004);
		cmd(`AFM_OP_PLAY, 16'h0003);
		rst <= 1'b1;
		tick(3);
		rst <= 1'b0;
		cmd(`AFM_OP_PUP, 16'h0000);
		error_read_cmd(8'h00);
		tick(6);
		check(expQ.size(), 32'h0);
		cmd(`AFM_OP_POWER_DOWN_CMD, 16'h0000);
		printVerdict();
	end
endmodule
